// File: nibble_alu.sv
// Four-bit arithmetic unit of the nibble core.
// Assumes operands are stable in the cycle it is read.
`timescale 1ns/1ps
`default_nettype none
module nibble_alu (
  // Operands
  input wire logic [3:0] a,
  input wire logic [3:0] b,
  input wire logic carry_in,
  input wire nibble_decoder_pkg::alu_op_type op,
  // Result
  output logic [3:0] result,
  output logic carry_out,
  output logic zero
);
  import nibble_decoder_pkg::*;

  logic [4:0] wide;

  // ------------------------------------------------------------
  // Datapath
  // ------------------------------------------------------------
  // carry or borrow
  always_comb begin
    case (op)
      ALU_ADD: wide = {1'b0, a} + {1'b0, b} + {4'h0, carry_in};
      ALU_SUB: wide = {1'b0, a} - {1'b0, b} - {4'h0, carry_in};
      ALU_OR: wide = {1'b0, a | b};
      default: wide = {1'b0, b};
    endcase
  end

  assign result = wide[3:0];
  assign carry_out = wide[4];
  assign zero = (wide[3:0] == 4'h0);
endmodule // nibble_alu
`default_nettype wire

// File: nibble_cpu_instruction_decoder_tb.sv
// Bench for the nibble decoder: feeds words, checks memory and state.
// Assumes the memory model answers in the same cycle.
`timescale 1ns/1ps
`default_nettype none
module nibble_cpu_instruction_decoder_tb;
  import nibble_decoder_pkg::*;
  logic clk = 1'b0, reset_n = 1'b0, irq_take = 1'b0, pf = 1'b0;
  logic [15:0] instr = 16'h0000;
  logic [2:0] rp = 3'h0, bank = 3'h0;
  logic [3:0] st = 4'h0;
  logic [PC_W-1:0] pc;
  logic [6:0] mem_addr;
  logic [3:0] mem_rdata, mem_wdata, reg_rdata, reg_addr, reg_wdata, isr, r3;
  logic mem_we, reg_we, carry_flag;
  logic [15:0] ap, ix;
  logic [2:0] sp;
  int n_errors = 0, samples_checked = 0;
  always #2 clk = ~clk;
  assign r3 = nibble_mem_model_inst.regs[3];
  nibble_decoder nibble_decoder_inst (.clk, .reset_n, .instr, .pc,
    .mem_rdata, .mem_addr, .mem_wdata, .mem_we, .reg_rdata, .reg_addr,
    .reg_wdata, .reg_we, .pointer_enable_flag(pf), .row_pointer_reg(rp),
    .bank, .periph_addr_hi(), .periph_addr_lo(), .regfile_row(),
    .regfile_col(), .irq_take, .auto_saved_status(st), .irq_stack_reg(isr),
    .carry_flag, .address_pointer_reg(ap), .index_pointer_reg(ix),
    .stack_ptr(sp));
  nibble_mem_model nibble_mem_model_inst (.clk, .mem_addr, .mem_wdata,
    .mem_we, .mem_rdata, .reg_addr, .reg_wdata, .reg_we, .reg_rdata);
  function automatic logic [15:0] enc(input logic [4:0] o,
    input logic [2:0] r, input logic [3:0] c, input logic [3:0] l);
    return {o, r, c, l};
  endfunction
  task automatic chk(input string what, input logic [15:0] e,
    input logic [15:0] g);
    samples_checked++;
    if (g !== e) begin
      n_errors++;
      $display("ERROR %s expected %h seen %h", what, e, g);
    end
  endtask
  task automatic chk_mem(input logic [6:0] a, input logic [3:0] e);
    chk("dmem", 16'(e), 16'(nibble_mem_model_inst.dmem[a]));
  endtask
  // One word per call, driven just after an edge, run at the next
  task automatic exec(input logic [15:0] w);
    instr = w;
    @(posedge clk);
    #1;
  endtask
  task automatic tally_and_finish();
    $display("checks %0d errors %0d", samples_checked, n_errors);
    if (n_errors == 0 && samples_checked > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask
  // Watchdog far beyond the few dozen cycles the run needs
  initial begin
    #4000;
    n_errors++;
    tally_and_finish();
  end
  initial begin
    repeat (2) @(posedge clk);
    #1 reset_n = 1'b1;
    exec(enc(OP_ADD_MI, 1, 2, 9));
    chk_mem(7'h12, 4'h9);
    exec(enc(OP_ADD_MI, 1, 2, 9));
    chk_mem(7'h12, 4'h2);
    chk("carry", 16'h1, 16'(carry_flag));
    exec(enc(OP_ADD_WITH_CARRY_MI, 0, 5, 3));
    chk_mem(7'h05, 4'h4);
    exec(enc(OP_ADD_RM, 1, 2, 3));
    chk("r3", 16'h2, 16'(r3));
    exec(enc(OP_ADD_MI, 0, 6, 4'hF));
    exec(enc(OP_ADD_MI, 0, 6, 1));
    exec(enc(OP_ADD_WITH_CARRY_RM, 1, 2, 3));
    chk("r3", 16'h5, 16'(r3));
    exec(enc(OP_SUB_RM, 0, 5, 3));
    chk("r3", 16'h1, 16'(r3));
    exec(enc(OP_SUB_MI, 0, 5, 6));
    chk_mem(7'h05, 4'hE);
    chk("borrow", 16'h1, 16'(carry_flag));
    exec(enc(OP_SUBTRACT_WITH_BORROW_MI, 1, 2, 0));
    chk_mem(7'h12, 4'h1);
    exec(enc(OP_SUBTRACT_WITH_BORROW_RM, 0, 5, 3));
    chk("r3", 16'h3, 16'(r3));
    exec(enc(OP_OR_RM, 0, 5, 3));
    chk("r3", 16'hF, 16'(r3));
    exec(enc(OP_MISC, 0, SUB_INC_AR, LAST_ZERO));
    exec(enc(OP_MISC, 0, SUB_INC_AR, LAST_ZERO));
    exec(enc(OP_MISC, 0, SUB_INC_IX, LAST_ZERO));
    chk("ap", 16'h2, ap);
    chk("ix", 16'h1, ix);
    // Equal compare swallows the next word, unequal does not
    exec(enc(OP_SKE, 1, 2, 1));
    exec(enc(OP_MISC, 0, SUB_INC_AR, LAST_ZERO));
    chk("ap", 16'h2, ap);
    exec(enc(OP_SKE, 1, 2, 2));
    exec(enc(OP_MISC, 0, SUB_INC_AR, LAST_ZERO));
    chk("ap", 16'h3, ap);
    for (int p = 0; p < 4; p++) begin
      exec({OP_BR_P0[4:2], 2'(p), 11'h2A5});
      chk("pc", {3'h0, 2'(p), 11'h2A5}, 16'(pc));
    end
    exec({OP_CALL_P0, 11'h155});
    chk("pc", 16'h0155, 16'(pc));
    chk("sp", 16'h7, 16'(sp));
    exec(enc(OP_MISC, 0, SUB_RET, LAST_ZERO));
    chk("sp", 16'h0, 16'(sp));
    // Return lands on the word after the call at page 3, 0x2A5
    chk("pc", 16'h1AA6, 16'(pc));
    irq_take = 1'b1;
    st = 4'hA;
    exec(enc(OP_MISC, 0, SUB_INC_IX, LAST_ZERO));
    irq_take = 1'b0;
    chk("irq_stack", 16'hA, 16'(isr));
    chk("sp", 16'h7, 16'(sp));
    // Indirect row from pointer, then from bank and row field; the
    // move itself lies outside this block, so the address is judged
    // while the word still stands (r3 holds 0xF here)
    pf = 1'b1;
    rp = 3'h5;
    bank = 3'h3;
    exec(enc(OP_MOV_IND_W, 1, 2, 3));
    chk("mem_addr", 16'h5F, 16'(mem_addr));
    pf = 1'b0;
    exec(enc(OP_MOV_IND_W, 1, 2, 3));
    chk("mem_addr", 16'h2F, 16'(mem_addr));
    tally_and_finish();
  end
endmodule // nibble_cpu_instruction_decoder_tb
bind nibble_decoder nibble_decoder_asserts nibble_decoder_asserts_inst (
  .clk, .reset_n, .instr, .pc, .mem_rdata, .mem_addr, .mem_we, .reg_rdata,
  .reg_wdata, .reg_we, .periph_addr_hi, .periph_addr_lo, .regfile_row,
  .regfile_col, .address_pointer_reg, .irq_take, .pointer_enable_flag,
  .row_pointer_reg);
`default_nettype wire

// File: nibble_decoder.sv
// Decoder and executor of the arithmetic group and control flow.
// Assumes program and data memory answer combinationally in the
// same cycle; one instruction completes per clock.
`timescale 1ns/1ps
`default_nettype none
module nibble_decoder (
  // Clock and reset
  input wire logic clk,
  input wire logic reset_n,
  // Program memory
  input wire logic [15:0] instr,
  output logic [nibble_decoder_pkg::PC_W-1:0] pc,
  // Data memory
  input wire logic [3:0] mem_rdata,
  output logic [6:0] mem_addr,
  output logic [3:0] mem_wdata,
  output logic mem_we,
  // General register file (column r)
  input wire logic [3:0] reg_rdata,
  output logic [3:0] reg_addr,
  output logic [3:0] reg_wdata,
  output logic reg_we,
  // Indirect addressing state
  input wire logic pointer_enable_flag,
  input wire logic [2:0] row_pointer_reg,
  input wire logic [2:0] bank,
  // Peripheral and register file address fields
  output logic [2:0] periph_addr_hi,
  output logic [3:0] periph_addr_lo,
  output logic [2:0] regfile_row,
  output logic [3:0] regfile_col,
  // Interrupt
  input wire logic irq_take,
  input wire logic [3:0] auto_saved_status,
  output logic [3:0] irq_stack_reg,
  // Status
  output logic carry_flag,
  output logic [15:0] address_pointer_reg,
  output logic [15:0] index_pointer_reg,
  output logic [2:0] stack_ptr
);
  import nibble_decoder_pkg::*;

  // ------------------------------------------------------------
  // State
  // ------------------------------------------------------------
  typedef struct packed {
    logic [PC_W-1:0] pc;
    logic carry;
    logic skip;
    logic [15:0] ar;
    logic [15:0] ix;
    logic [2:0] sp;
    logic [3:0] irq_stack;
    logic [STACK_DEPTH*PC_W-1:0] stack;
  } state_type;

  state_type state_ff;
  state_type nxt_state;

  // ------------------------------------------------------------
  // Field extraction
  // ------------------------------------------------------------
  // opcode field
  logic [4:0] opc;
  logic [2:0] row_f;
  logic [3:0] col_f;
  logic [3:0] low_f;
  logic [10:0] addr_f;
  assign opc = instr[OPC_MSB:OPC_LSB];
  assign row_f = instr[ROW_MSB:ROW_LSB];
  assign col_f = instr[COL_MSB:COL_LSB];
  assign low_f = instr[LOW_MSB:LOW_LSB];
  assign addr_f = instr[ADDR_MSB:0];

  assign periph_addr_hi = row_f;
  assign periph_addr_lo = low_f;
  assign regfile_row = row_f;
  assign regfile_col = low_f;

  logic indirect;
  assign indirect = (opc == OP_MOV_IND_W) || (opc == OP_MOV_IND_R);
  always_comb begin
    if (indirect && pointer_enable_flag) begin
      mem_addr = {row_pointer_reg, reg_rdata};
    end else if (indirect) begin
      mem_addr = {row_f ^ bank, reg_rdata};
    end else begin
      mem_addr = {row_f, col_f};
    end
  end
  assign reg_addr = low_f;

  // ------------------------------------------------------------
  // Arithmetic unit
  // ------------------------------------------------------------
  logic imm_form;
  logic use_carry;
  alu_op_type alu_op;
  logic [3:0] alu_a;
  logic [3:0] alu_b;
  logic [3:0] alu_res;
  logic alu_cout;
  logic alu_zero;

  assign imm_form = opc[4];
  always_comb begin
    alu_op = ALU_PASS;
    use_carry = 1'b0;
    case (opc & 5'h0F)
      5'h00: alu_op = ALU_ADD;
      5'h01: alu_op = ALU_SUB;
      5'h02: begin
        alu_op = ALU_ADD;
        use_carry = 1'b1;
      end
      5'h03: begin
        alu_op = ALU_SUB;
        use_carry = 1'b1;
      end
      5'h06: alu_op = ALU_OR;
      5'h09: alu_op = ALU_SUB;
      default: alu_op = ALU_PASS;
    endcase
  end
  assign alu_a = imm_form || (opc == OP_SKE) ? mem_rdata : reg_rdata;
  assign alu_b = imm_form || (opc == OP_SKE) ? low_f : mem_rdata;

  nibble_alu nibble_alu_inst (
    .a(alu_a),
    .b(alu_b),
    .carry_in(use_carry & state_ff.carry),
    .op(alu_op),
    .result(alu_res),
    .carry_out(alu_cout),
    .zero(alu_zero)
  );

  // ------------------------------------------------------------
  // Next state
  // ------------------------------------------------------------
  logic is_arith;
  logic [PC_W-1:0] pc_inc;
  logic [2:0] sp_dec;
  assign is_arith = (opc[3:0] <= 4'h3) && (opc != OP_MISC);
  assign pc_inc = state_ff.pc + 13'h0001;
  assign sp_dec = state_ff.sp - 3'h1;

  always_comb begin
    nxt_state = state_ff;
    nxt_state.pc = pc_inc;
    nxt_state.skip = 1'b0;
    mem_we = 1'b0;
    mem_wdata = alu_res;
    reg_we = 1'b0;
    reg_wdata = alu_res;
    if (state_ff.skip) begin
      // Skipped word does nothing but advance the counter
    end else if (irq_take) begin
      nxt_state.irq_stack = auto_saved_status;
      nxt_state.sp = sp_dec;
      nxt_state.stack[sp_dec*PC_W +: PC_W] = state_ff.pc;
      nxt_state.pc = state_ff.pc;
    end else begin
      case (opc)
        OP_ADD_RM, OP_SUB_RM, OP_ADD_WITH_CARRY_RM, OP_SUBTRACT_WITH_BORROW_RM, OP_OR_RM: begin
          reg_we = 1'b1;
          if (is_arith) nxt_state.carry = alu_cout;
        end
        OP_ADD_MI, OP_SUB_MI, OP_ADD_WITH_CARRY_MI, OP_SUBTRACT_WITH_BORROW_MI: begin
          mem_we = 1'b1;
          nxt_state.carry = alu_cout;
        end
        OP_SKE: nxt_state.skip = alu_zero;
        OP_BR_P0, OP_BR_P1, OP_BR_P2, OP_BR_P3:
          nxt_state.pc = {opc[1:0], addr_f};
        OP_CALL_P0: begin
          nxt_state.sp = sp_dec;
          nxt_state.stack[sp_dec*PC_W +: PC_W] = pc_inc;
          nxt_state.pc = {2'b00, addr_f};
        end
        OP_MISC: begin
          if (col_f == SUB_INC_AR && low_f == LAST_ZERO)
            nxt_state.ar = state_ff.ar + 16'h0001;
          else if (col_f == SUB_INC_IX && low_f == LAST_ZERO)
            nxt_state.ix = state_ff.ix + 16'h0001;
          else if (col_f == SUB_RET && low_f == LAST_ZERO) begin
            nxt_state.pc = state_ff.stack[state_ff.sp*PC_W +: PC_W];
            nxt_state.sp = state_ff.sp + 3'h1;
          end
        end
        default: begin
          // Other groups are handled outside this block
        end
      endcase
    end
  end

  // ------------------------------------------------------------
  // Registers
  // ------------------------------------------------------------
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      state_ff <= '0;
    end else begin
      state_ff <= nxt_state;
    end
  end

  assign pc = state_ff.pc;
  assign carry_flag = state_ff.carry;
  assign address_pointer_reg = state_ff.ar;
  assign index_pointer_reg = state_ff.ix;
  assign stack_ptr = state_ff.sp;
  assign irq_stack_reg = state_ff.irq_stack;
endmodule // nibble_decoder
`default_nettype wire

// File: nibble_decoder_asserts.sv
// Port checker for the nibble decoder.
// Assumes a bind from the bench top; one clock, async reset.
`timescale 1ns/1ps
`default_nettype none
module nibble_decoder_asserts (
  // Clock and reset
  input wire logic clk,
  input wire logic reset_n,
  // Memory side
  input wire logic [15:0] instr,
  input wire logic [nibble_decoder_pkg::PC_W-1:0] pc,
  input wire logic [3:0] mem_rdata,
  input wire logic [6:0] mem_addr,
  input wire logic mem_we,
  input wire logic [3:0] reg_rdata,
  input wire logic [3:0] reg_wdata,
  input wire logic reg_we,
  // Interrupt and indirect row sources
  input wire logic irq_take,
  input wire logic pointer_enable_flag,
  input wire logic [2:0] row_pointer_reg,
  // Fields and status
  input wire logic [2:0] periph_addr_hi,
  input wire logic [3:0] periph_addr_lo,
  input wire logic [2:0] regfile_row,
  input wire logic [3:0] regfile_col,
  input wire logic [15:0] address_pointer_reg
);
  import nibble_decoder_pkg::*;
  logic [4:0] opc;
  logic [PC_W-1:0] target;
  assign opc = instr[OPC_MSB:OPC_LSB];
  assign target = instr[PC_W-1:0];
  default clocking cb @(posedge clk); endclocking
  default disable iff (!reset_n);
  // A word after a compare may be skipped, so it is left unjudged;
  // an interrupt cycle pre-empts the word, so it is left out too
  a_add_reg_sum: assert property (opc == OP_ADD_RM && !irq_take
    && $past(opc) != OP_SKE
    |-> reg_we && !mem_we && reg_wdata == reg_rdata + mem_rdata)
    else $error("add result wrong");
  a_imm_mem_write: assert property (opc[4:2] == 3'b100 && !irq_take
    && $past(opc) != OP_SKE
    |-> mem_we && !reg_we && mem_addr == instr[10:4])
    else $error("immediate write wrong");
  a_sub_reg_diff: assert property (opc == OP_SUB_RM && !irq_take
    && $past(opc) != OP_SKE
    |-> reg_we && reg_wdata == reg_rdata - mem_rdata)
    else $error("sub result wrong");
  a_or_reg_result: assert property (opc == OP_OR_RM && !irq_take
    && $past(opc) != OP_SKE
    |-> reg_we && reg_wdata == (reg_rdata | mem_rdata))
    else $error("or result wrong");
  a_inc_pointer: assert property (instr == 16'h3890 && !irq_take
    && $past(opc) != OP_SKE
    |=> address_pointer_reg == $past(address_pointer_reg) + 16'h0001)
    else $error("pointer increment wrong");
  a_branch_page: assert property (opc[4:2] == 3'b011 && !irq_take
    && $past(opc) != OP_SKE
    |=> pc == $past(target))
    else $error("branch target wrong");
  a_periph_fields: assert property (periph_addr_hi == instr[10:8]
    && periph_addr_lo == instr[3:0]) else $error("peripheral field wrong");
  a_regfile_fields: assert property (regfile_row == instr[10:8]
    && regfile_col == instr[3:0]) else $error("register file field wrong");
  a_mem_addr_fields: assert property (opc inside {5'h00, 5'h01, 5'h02, 5'h03}
    |-> mem_addr == instr[10:4]) else $error("memory address wrong");
  a_ind_row_ptr: assert property ((opc == OP_MOV_IND_W ||
    opc == OP_MOV_IND_R) && pointer_enable_flag
    |-> mem_addr[6:4] == row_pointer_reg) else $error("indirect row wrong");
endmodule // nibble_decoder_asserts
`default_nettype wire

// File: nibble_decoder_pkg.sv
// Constants, field layout and opcodes of the nibble core decoder.
// Assumes a single 250 MHz clock and asynchronous active-low reset.
//
// Summary of operation
// - opcode 00000 adds memory nibble into register
// - opcode 10000 adds immediate into memory nibble
// - 00010/10010 add with carry flag included
// - 00111 sub-code 1001/1000 increments pointer/index
// - 00001/10001 subtract into register or memory
// - 00011/10011 subtract also taking carry borrow
// - opcode 00110 ORs memory nibble into register
// - direct branch/call loads eleven low counter bits
// - branch opcode picks page in counter bits 12:11
// - call/interrupt write stack entry at pointer minus one, return reads at current pointer
// - immediate and bit mask fields four bits
// - peripheral address split three high, four low
// - register file address three row, four column
// - interrupt saves status word to irq stack
// - direct memory address from row and column fields
// - indirect row from pointer when enable set
// - compare immediate skips next when equal
package nibble_decoder_pkg;

  // ------------------------------------------------------------
  // Field layout
  // ------------------------------------------------------------
  localparam int OPC_MSB = 15;
  localparam int OPC_LSB = 11;
  localparam int ROW_MSB = 10;
  localparam int ROW_LSB = 8;
  localparam int COL_MSB = 7;
  localparam int COL_LSB = 4;
  localparam int LOW_MSB = 3;
  localparam int LOW_LSB = 0;
  localparam int ADDR_MSB = 10;
  localparam int PC_W = 13;
  localparam int STACK_DEPTH = 8;

  // ------------------------------------------------------------
  // Opcodes
  // ------------------------------------------------------------
  localparam logic [4:0] OP_ADD_RM = 5'h00;
  localparam logic [4:0] OP_SUB_RM = 5'h01;
  localparam logic [4:0] OP_ADD_WITH_CARRY_RM = 5'h02;
  localparam logic [4:0] OP_SUBTRACT_WITH_BORROW_RM = 5'h03;
  localparam logic [4:0] OP_OR_RM = 5'h06;
  localparam logic [4:0] OP_MISC = 5'h07;
  localparam logic [4:0] OP_SKE = 5'h09;
  localparam logic [4:0] OP_MOV_IND_W = 5'h0A;
  localparam logic [4:0] OP_BR_P0 = 5'h0C;
  localparam logic [4:0] OP_BR_P1 = 5'h0D;
  localparam logic [4:0] OP_BR_P2 = 5'h0E;
  localparam logic [4:0] OP_BR_P3 = 5'h0F;
  localparam logic [4:0] OP_ADD_MI = 5'h10;
  localparam logic [4:0] OP_SUB_MI = 5'h11;
  localparam logic [4:0] OP_ADD_WITH_CARRY_MI = 5'h12;
  localparam logic [4:0] OP_SUBTRACT_WITH_BORROW_MI = 5'h13;
  localparam logic [4:0] OP_MOV_IND_R = 5'h1A;
  localparam logic [4:0] OP_CALL_P0 = 5'h1C;

  // Sub-codes of the miscellaneous group (bits 7:4)
  localparam logic [3:0] SUB_INC_IX = 4'h8;
  localparam logic [3:0] SUB_INC_AR = 4'h9;
  localparam logic [3:0] SUB_RET = 4'hE;
  localparam logic [3:0] SUB_PUSH = 4'hD;
  localparam logic [3:0] SUB_POP = 4'hC;
  localparam logic [3:0] SUB_GET = 4'hB;
  localparam logic [3:0] SUB_PUT = 4'hA;
  localparam logic [3:0] SUB_PEEK = 4'h3;
  localparam logic [3:0] SUB_POKE = 4'h2;
  localparam logic [3:0] LAST_ZERO = 4'h0;

  // Reset values
  localparam logic [PC_W-1:0] PC_RST = 13'h0000;
  localparam logic [2:0] SP_RST = 3'h0;
  localparam logic [15:0] PTR_RST = 16'h0000;

  // Arithmetic unit operations
  typedef enum logic [2:0] {
    ALU_ADD = 3'b000,
    ALU_SUB = 3'b001,
    ALU_OR = 3'b010,
    ALU_PASS = 3'b011
  } alu_op_type;

endpackage

// File: nibble_mem_model.sv
// Data memory and general register model behind the decoder.
// Assumes writes land on the edge where the strobe is seen.
`timescale 1ns/1ps
`default_nettype none
module nibble_mem_model (
  // Clock
  input wire logic clk,
  // Data memory
  input wire logic [6:0] mem_addr,
  input wire logic [3:0] mem_wdata,
  input wire logic mem_we,
  output logic [3:0] mem_rdata,
  // General registers
  input wire logic [3:0] reg_addr,
  input wire logic [3:0] reg_wdata,
  input wire logic reg_we,
  output logic [3:0] reg_rdata
);
  logic [3:0] dmem [128];
  logic [3:0] regs [16];
  // Cleared at time zero so that expectations start from zero
  initial begin
    for (int i = 0; i < 128; i++)
      dmem[i] = 4'h0;
    for (int i = 0; i < 16; i++)
      regs[i] = 4'h0;
  end
  assign mem_rdata = dmem[mem_addr];
  assign reg_rdata = regs[reg_addr];
  // Plain always since the arrays are also preset above
  always @(posedge clk) begin
    if (mem_we)
      dmem[mem_addr] <= mem_wdata;
    if (reg_we)
      regs[reg_addr] <= reg_wdata;
  end
endmodule // nibble_mem_model
`default_nettype wire
